/* File: src/pms_pkg.sv */
// Package of constants for the power-mode and reset sequencer
package pms_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [11:0] PMS_ADDR_CTRL = 12'h000; // Control bits
   localparam logic [11:0] PMS_ADDR_MODE = 12'h004; // Mode and clock setup
   localparam logic [11:0] PMS_ADDR_STAT = 12'h008; // Status flags
   localparam logic [11:0] PMS_ADDR_CMD = 12'h00c;  // Command register
   localparam logic [11:0] PMS_ADDR_STATE = 12'h010; // Power state
   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int PMS_CTRL_ANALOG_SUPPLY_ENABLE_BIT = 0;  // Analog supply enable
   localparam int PMS_CTRL_OUTPUT_SUPPLY_ENABLE_BIT = 1; // Output supply enable
   localparam int PMS_CTRL_CLK_EN = 2;   // Clock output enable
   localparam logic [2:0] PMS_CTRL_RST = 3'h6; // Supply and clock on
   // ----------------------------------------------------------------
   // Mode register fields
   // ----------------------------------------------------------------
   localparam int PMS_MODE_OPM_LO = 0;  // Operating mode field base
   localparam int PMS_MODE_BRR_LO = 2;  // Bit-rate range field base
   localparam int PMS_MODE_LIM_LO = 4;  // Limit factor field base
   localparam logic [1:0] PMS_OPM_RST = 2'h0;  // Idle after reset
   localparam logic [1:0] PMS_BRR_RST = 2'h0;  // Slowest range
   localparam logic [3:0] PMS_LIM_RST = 4'h1;  // Limit factor
   // ----------------------------------------------------------------
   // Status bits
   // ----------------------------------------------------------------
   localparam int PMS_ST_BTN_LO = 0;   // Five button flags
   localparam int PMS_ST_PWRON = 5;    // Power-on flag
   localparam int PMS_ST_AUX = 6;      // Auxiliary power flag
   localparam int PMS_ST_LOWBAT = 7;   // Low battery flag
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] PMS_CMD_OFF = 8'ha5; // Return to OFF
   // ----------------------------------------------------------------
   // Clock dividers
   // ----------------------------------------------------------------
   localparam logic [3:0] PMS_BASE_DIV = 4'hf;   // Divide by 16, minus 1
   localparam logic [1:0] PMS_CLKOUT_DIV = 2'h2; // Divide by 3, minus 1
   localparam logic [1:0] PMS_CLKOUT_HALF = 2'h1; // High for first of three counts
   // Power states
   typedef enum logic [1:0] {PMS_OFF, PMS_AUX, PMS_IDLE} pms_state_t;
endpackage : pms_pkg

/* File: src/pms_sequencer.sv */
// Power-mode and reset sequencer with APB register access
// Behaviour
// RULE1 - base clock is oscillator divided by 16
// RULE2 - base clock times polling and bit rate
// RULE3 - sub-clock period base times limit times 8/4/2/1
// RULE4 - OFF keeps supplies off, ignores bus
// RULE5 - auxiliary supply moves OFF to aux
// RULE6 - OFF to aux raises irq, aux flag
// RULE7 - power-on or button moves OFF to idle
// RULE8 - aux to idle by enable bit or pins
// RULE9 - idle picks aux regulator when much higher
// RULE10 - RF stays off until host enables
// RULE11 - host clears inputs before OFF command
// RULE12 - switch-on clears logic and loads defaults
// RULE13 - reset output low until supply and oscillator
// RULE14 - clock out after low threshold and oscillator
// RULE15 - low battery clears after recover and read
// RULE16 - low supply resets; internal only if enabled
// RULE17 - low supply holds clock low, bus off
// RULE18 - output supply off by bit, on by switch-on
// RULE19 - reset output from set/reset latch
// RULE20 - oscillator ready releases reset, enables clock
// RULE21 - clock out is oscillator divided by 3
// RULE22 - mode field reads idle after reset
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pms_sequencer
   import pms_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_clk_tick,        // One pulse per oscillator cycle
   input wire logic oscillator_ready,    // Amplitude detector
   input wire logic aux_above_threshold, // Auxiliary supply comparator
   input wire logic aux_above_battery,   // Aux exceeds battery by margin
   input wire logic output_supply_good,  // Above lower threshold
   input wire logic output_supply_high,  // Above upper threshold
   input wire logic power_on_input,
   input wire logic [4:0] button_input_n, // Buttons, active low
   output logic analog_supply_on,
   output logic logic_supply_on,
   output logic output_supply_on,
   output logic aux_regulator_sel,
   output logic rf_enable,
   output logic irq,
   output logic mcu_reset_n,
   output logic clk_out,
   output logic base_tick,
   output logic sub_tick
);
   // ----------------------------------------------------------------
   // State and registers
   // ----------------------------------------------------------------
   pms_state_t state_r;        // Power state
   logic [2:0] ctrl_r;         // Control bits
   logic [1:0] opm_r;          // Operating mode
   logic [1:0] brr_r;          // Bit-rate range
   logic [3:0] lim_r;          // Limit factor
   logic [7:0] stat_r;         // Sticky status flags
   logic irq_r;                // Interrupt level
   logic int_rst;              // Internal logic reset, held while its cause lasts
   logic rst_latch_r;          // Reset output latch
   logic [3:0] base_cnt_r;     // Divide-by-16 counter
   logic [6:0] sub_cnt_r;      // Sub-clock counter
   logic [1:0] clk_cnt_r;      // Divide-by-3 counter
   logic clk_out_r;
   logic base_tick_r;
   logic sub_tick_r;
   logic [31:0] prdata_r;
   logic wake_pins;            // Any switch-on pin active
   logic bus_on;               // Host interface alive
   logic acc, wr, rd;
   logic [6:0] sub_len;        // Sub-clock length in base ticks
   // Decode one address against a register offset
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] off);
      hit = (a == off);
   endfunction : hit
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Interface dead in OFF and while supply is low; accesses still end
   assign bus_on = (state_r != PMS_OFF) && output_supply_good; // RULE4 RULE17
   assign acc = psel && penable;
   assign wr = acc && pwrite && bus_on;
   assign rd = acc && !pwrite && bus_on;
   assign pready = 1'b1;
   assign pslverr = acc && !(hit(paddr, PMS_ADDR_CTRL) ||
      hit(paddr, PMS_ADDR_MODE) || hit(paddr, PMS_ADDR_STAT) ||
      hit(paddr, PMS_ADDR_CMD) || hit(paddr, PMS_ADDR_STATE));
   assign wake_pins = power_on_input || (button_input_n != 5'h1f);
   // ----------------------------------------------------------------
   // Internal logic reset
   // ----------------------------------------------------------------
   // One cycle on switch-on; held while supply is low with the supply enabled
   assign int_rst = (state_r == PMS_OFF && (aux_above_threshold ||
      wake_pins)) || // RULE12
      (state_r != PMS_OFF && !output_supply_good &&
      ctrl_r[PMS_CTRL_OUTPUT_SUPPLY_ENABLE_BIT]); // RULE16
   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= PMS_OFF;
      end else begin
         case (state_r)
            PMS_OFF: begin
               if (wake_pins) begin
                  state_r <= PMS_IDLE; // RULE7
               end else if (aux_above_threshold) begin
                  state_r <= PMS_AUX; // RULE5
               end
            end
            PMS_AUX: begin
               // Enable bit or pins finish the switch-on
               if (ctrl_r[PMS_CTRL_ANALOG_SUPPLY_ENABLE_BIT] || wake_pins) begin
                  state_r <= PMS_IDLE; // RULE8
               end
            end
            PMS_IDLE: begin
               // Host has cleared enable and pins beforehand
               if (wr && hit(paddr, PMS_ADDR_CMD) &&
                   pwdata[7:0] == PMS_CMD_OFF) begin
                  state_r <= PMS_OFF; // RULE11
               end
            end
            default: state_r <= PMS_OFF;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Control and mode registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= PMS_CTRL_RST;
         opm_r <= PMS_OPM_RST;
         brr_r <= PMS_BRR_RST;
         lim_r <= PMS_LIM_RST;
      end else if (int_rst) begin
         // Defaults reload; output supply back on at switch-on
         ctrl_r <= PMS_CTRL_RST; // RULE12 RULE18
         opm_r <= PMS_OPM_RST; // RULE22
         brr_r <= PMS_BRR_RST;
         lim_r <= PMS_LIM_RST;
      end else if (wake_pins && !ctrl_r[PMS_CTRL_OUTPUT_SUPPLY_ENABLE_BIT]) begin
         // Switch-on pin brings a host-disabled output supply back
         ctrl_r[PMS_CTRL_OUTPUT_SUPPLY_ENABLE_BIT] <= 1'b1; // RULE18
      end else if (wr && hit(paddr, PMS_ADDR_CTRL)) begin
         ctrl_r <= pwdata[2:0]; // RULE18
      end else if (wr && hit(paddr, PMS_ADDR_MODE)) begin
         opm_r <= pwdata[PMS_MODE_OPM_LO +: 2];
         brr_r <= pwdata[PMS_MODE_BRR_LO +: 2];
         lim_r <= pwdata[PMS_MODE_LIM_LO +: 4];
      end
   end
   // ----------------------------------------------------------------
   // Status flags and interrupt
   // ----------------------------------------------------------------
   // Sets beat the read clear so no event is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= 8'h00;
         irq_r <= 1'b0;
      end else begin
         if (rd && hit(paddr, PMS_ADDR_STAT)) begin
            irq_r <= 1'b0;
            stat_r[PMS_ST_BTN_LO +: 5] <= 5'h00;
            stat_r[PMS_ST_PWRON] <= 1'b0;
            stat_r[PMS_ST_AUX] <= 1'b0;
            // Low battery only clears once supply recovered
            if (output_supply_high) begin
               stat_r[PMS_ST_LOWBAT] <= 1'b0; // RULE15
            end
         end
         if (state_r == PMS_OFF && wake_pins) begin
            stat_r[PMS_ST_BTN_LO +: 5] <= ~button_input_n; // RULE7
            stat_r[PMS_ST_PWRON] <= power_on_input;
            irq_r <= 1'b1;
         end else if (state_r == PMS_OFF && aux_above_threshold) begin
            stat_r[PMS_ST_AUX] <= 1'b1; // RULE6
            irq_r <= 1'b1;
         end
         if (state_r == PMS_IDLE && aux_above_battery) begin
            stat_r[PMS_ST_AUX] <= 1'b1; // RULE9
         end
         if (state_r != PMS_OFF && !output_supply_high) begin
            stat_r[PMS_ST_LOWBAT] <= 1'b1; // RULE15
         end
      end
   end
   // ----------------------------------------------------------------
   // Reset output latch
   // ----------------------------------------------------------------
   // Release at upper threshold, assert at lower: the hysteresis
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_latch_r <= 1'b0;
      end else if (state_r == PMS_OFF || !output_supply_good) begin
         rst_latch_r <= 1'b0; // RULE16 RULE19
      end else if (output_supply_high && oscillator_ready) begin
         rst_latch_r <= 1'b1; // RULE13 RULE19 RULE20
      end
   end
   // ----------------------------------------------------------------
   // Base and sub-clock dividers
   // ----------------------------------------------------------------
   // Sub-clock length: limit shifted by 3 minus range
   assign sub_len = 7'({3'h0, lim_r} << (2'd3 - brr_r)); // RULE3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_cnt_r <= 4'h0;
         sub_cnt_r <= 7'h00;
         base_tick_r <= 1'b0;
         sub_tick_r <= 1'b0;
      end else begin
         base_tick_r <= 1'b0;
         sub_tick_r <= 1'b0;
         if (osc_clk_tick) begin
            if (base_cnt_r == PMS_BASE_DIV) begin
               base_cnt_r <= 4'h0;
               base_tick_r <= 1'b1; // RULE1 RULE2
               if (sub_cnt_r + 7'h01 >= sub_len) begin
                  sub_cnt_r <= 7'h00;
                  sub_tick_r <= 1'b1; // RULE3
               end else begin
                  sub_cnt_r <= sub_cnt_r + 7'h01;
               end
            end else begin
               base_cnt_r <= base_cnt_r + 4'h1;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // Clock output
   // ----------------------------------------------------------------
   // Gate takes effect mid-cycle, so first output cycle may be short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_cnt_r <= 2'h0;
         clk_out_r <= 1'b0;
      end else begin
         if (osc_clk_tick) begin
            clk_cnt_r <= (clk_cnt_r == PMS_CLKOUT_DIV) ? 2'h0 :
               clk_cnt_r + 2'h1; // RULE21
         end
         clk_out_r <= (clk_cnt_r < PMS_CLKOUT_HALF) &&
            output_supply_good && oscillator_ready &&
            ctrl_r[PMS_CTRL_CLK_EN] && state_r != PMS_OFF; // RULE14 RULE17
      end
   end
   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= 32'h0;
         // Dead interface answers zero, so no stale state leaks out
         if (!bus_on) begin
            prdata_r <= 32'h0; // RULE4 RULE17
         end else if (hit(paddr, PMS_ADDR_CTRL)) begin
            prdata_r <= {29'h0, ctrl_r};
         end else if (hit(paddr, PMS_ADDR_MODE)) begin
            prdata_r <= {24'h0, lim_r, brr_r, opm_r};
         end else if (hit(paddr, PMS_ADDR_STAT)) begin
            prdata_r <= {24'h0, stat_r};
         end else if (hit(paddr, PMS_ADDR_STATE)) begin
            prdata_r <= {30'h0, state_r};
         end
      end
   end
   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_r;
   assign irq = irq_r;
   assign mcu_reset_n = rst_latch_r;
   assign clk_out = clk_out_r;
   assign base_tick = base_tick_r;
   assign sub_tick = sub_tick_r;
   assign logic_supply_on = (state_r != PMS_OFF); // RULE4
   assign analog_supply_on = (state_r == PMS_IDLE); // RULE5
   assign output_supply_on = logic_supply_on && ctrl_r[PMS_CTRL_OUTPUT_SUPPLY_ENABLE_BIT];
   assign aux_regulator_sel = (state_r == PMS_AUX) ||
      (state_r == PMS_IDLE && aux_above_battery); // RULE9
   // RF only after host picks a non-idle operating mode
   assign rf_enable = (state_r == PMS_IDLE) && (opm_r != PMS_OPM_RST); // RULE10
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_off_aux;
      state_r == PMS_OFF && !wake_pins && aux_above_threshold;
   endsequence
   property p_aux_irq;
      @(posedge pclk) disable iff (!presetn)
      s_off_aux |=> irq && stat_r[PMS_ST_AUX] && state_r == PMS_AUX;
   endproperty
   a_aux_irq: assert property (p_aux_irq) else $error("aux irq"); // RULE6
   property p_idle_wake;
      @(posedge pclk) disable iff (!presetn)
      (state_r == PMS_OFF && wake_pins) |=> state_r == PMS_IDLE && irq;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("wake"); // RULE7
   property p_off_quiet;
      @(posedge pclk) disable iff (!presetn)
      state_r == PMS_OFF |-> !logic_supply_on && !output_supply_on;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("off"); // RULE4
   property p_rst_low;
      @(posedge pclk) disable iff (!presetn)
      !output_supply_good |=> !mcu_reset_n && !clk_out;
   endproperty
   a_rst_low: assert property (p_rst_low) else $error("rst low"); // RULE16
   property p_rst_rel;
      @(posedge pclk) disable iff (!presetn)
      $rose(mcu_reset_n) |-> $past(output_supply_high && oscillator_ready);
   endproperty
   a_rst_rel: assert property (p_rst_rel) else $error("release"); // RULE13
   property p_lowbat;
      @(posedge pclk) disable iff (!presetn)
      $fell(stat_r[PMS_ST_LOWBAT]) |-> $past(output_supply_high);
   endproperty
   a_lowbat: assert property (p_lowbat) else $error("lowbat"); // RULE15
   property p_mode_dflt;
      @(posedge pclk) disable iff (!presetn)
      int_rst |=> opm_r == PMS_OPM_RST;
   endproperty
   a_mode_dflt: assert property (p_mode_dflt) else $error("mode"); // RULE22
   property p_rf_off;
      @(posedge pclk) disable iff (!presetn)
      rf_enable |-> state_r == PMS_IDLE && opm_r != 2'h0;
   endproperty
   a_rf_off: assert property (p_rf_off) else $error("rf"); // RULE10
endmodule : pms_sequencer
`default_nettype wire

/* File: tb/pms_env_model.sv */
// Pin-side environment model: oscillator and output supply monitors
`timescale 1ns/1ps
`default_nettype none
module pms_env_model #(
   parameter int START_CYC = 20 // Oscillator start-up, in pclk cycles
) (
   input wire logic pclk,
   input wire logic [15:0] output_supply_mv,    // Output supply level asked by bench
   input wire logic output_supply_on,   // Device drives the output supply
   input wire logic logic_supply_on,    // Device powers its own logic
   output logic osc_clk_tick,
   output logic oscillator_ready,
   output logic output_supply_good,
   output logic output_supply_high
);
   // ----------------------------------------------------------------
   // Oscillator start-up
   // ----------------------------------------------------------------
   int run_r; // Cycles since the logic supply came up

   // Amplitude builds only while the logic supply is on
   always_ff @(posedge pclk) begin
      if (!logic_supply_on) begin
         run_r <= 0;
      end else if (run_r < START_CYC) begin
         run_r <= run_r + 1;
      end
   end

   // Ready once the amplitude is large enough
   assign oscillator_ready = (run_r >= START_CYC);
   // One oscillator cycle per pclk keeps all periods in whole cycles
   assign osc_clk_tick = oscillator_ready;

   // ----------------------------------------------------------------
   // Supply monitors
   // ----------------------------------------------------------------
   // A switched-off supply reads as collapsed, whatever level is asked
   assign output_supply_good = output_supply_on && (output_supply_mv > 16'h08fc);
   assign output_supply_high = output_supply_on && (output_supply_mv > 16'h094c);
endmodule : pms_env_model
`default_nettype wire

/* File: tb/pms_sequencer_tb.sv */
// Testbench for the power-mode and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module pms_sequencer_tb;
   import pms_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic osc_clk_tick, oscillator_ready, output_supply_good;
   logic output_supply_high, aux_above_threshold, aux_above_battery;
   logic power_on_input, analog_supply_on, logic_supply_on;
   logic output_supply_on, aux_regulator_sel, rf_enable, irq;
   logic mcu_reset_n, clk_out, base_tick, sub_tick, e;
   logic [4:0] button_input_n;
   logic [15:0] output_supply_mv; // Output supply level in millivolts
   int fail_count, check_count, n;

   pms_sequencer i_pms_sequencer (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_clk_tick,
      .oscillator_ready, .aux_above_threshold, .aux_above_battery,
      .output_supply_good, .output_supply_high, .power_on_input,
      .button_input_n, .analog_supply_on, .logic_supply_on,
      .output_supply_on, .aux_regulator_sel, .rf_enable, .irq,
      .mcu_reset_n, .clk_out, .base_tick, .sub_tick);
   pms_env_model i_pms_env_model (.pclk, .output_supply_mv, .output_supply_on,
      .logic_supply_on, .osc_clk_tick, .oscillator_ready,
      .output_supply_good, .output_supply_high);

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Whole run needs well under this many cycles
   initial begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      $display("BAD %0t run timed out", $time);
      stop_test();
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic settle(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask : settle
   function automatic logic sig(input int s);
      case (s)
         0: return base_tick;
         1: return sub_tick;
         2: return clk_out;
         3: return irq;
         default: return mcu_reset_n;
      endcase
   endfunction : sig
   // Bounded wait for a design output to go high
   task automatic wait_hi(input int s);
      for (int k = 0; k < 300 && sig(s) !== 1'b1; k++) settle(1);
      chk(sig(s), 1'b1);
   endtask : wait_hi
   // Cycles between two rising edges of a design output
   task automatic gap(input int s);
      logic p;
      int t0;
      p = 1'b1;
      t0 = -1;
      n = -1;
      for (int k = 0; k < 600 && n < 0; k++) begin
         settle(1);
         if (sig(s) === 1'b1 && p !== 1'b1 && t0 >= 0) n = k - t0;
         if (sig(s) === 1'b1 && p !== 1'b1 && t0 < 0) t0 = k;
         p = sig(s);
      end
   endtask : gap
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, power_on_input} = 5'h00;
      {aux_above_threshold, aux_above_battery} = 2'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      button_input_n = 5'h1f;
      output_supply_mv = 16'h0bb8;
      fail_count = 0;
      check_count = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Powered down: supplies off, bus ignored
      settle(4);
      chk({analog_supply_on, logic_supply_on, output_supply_on}, 0);
      apb(1'b1, PMS_ADDR_CTRL, 32'h7);
      apb(1'b0, PMS_ADDR_CTRL, 32'h0);
      chk(rv, 32'h0);
      // Auxiliary supply switch-on
      aux_above_threshold <= 1'b1;
      wait_hi(3);
      wait_hi(4);
      apb(1'b0, PMS_ADDR_STATE, 32'h0);
      chk(rv, 32'h1);
      chk({analog_supply_on, rf_enable}, 0);
      apb(1'b0, PMS_ADDR_CTRL, 32'h0);
      chk(rv[2:0], PMS_CTRL_RST);
      apb(1'b0, PMS_ADDR_MODE, 32'h0);
      chk(rv[7:0], {PMS_LIM_RST, PMS_BRR_RST, PMS_OPM_RST});
      apb(1'b0, PMS_ADDR_STAT, 32'h0);
      chk(rv[6], 1'b1);
      settle(2);
      chk(irq, 1'b0);
      // Clock dividers
      gap(2);
      chk(n, 3);
      gap(0);
      chk(n, 16);
      for (int b = 0; b < 4; b++) begin
         apb(1'b1, PMS_ADDR_MODE, 32'h10 | (b << 2));
         gap(1);
         gap(1);
         chk(n, 16 * (8 >> b));
      end
      apb(1'b1, PMS_ADDR_MODE, 32'h2d);
      gap(1);
      gap(1);
      chk(n, 32);
      chk(rf_enable, 1'b0);
      // Auxiliary to idle by the analog enable bit
      apb(1'b1, PMS_ADDR_MODE, 32'h10);
      apb(1'b1, PMS_ADDR_CTRL, 32'h7);
      apb(1'b0, PMS_ADDR_STATE, 32'h0);
      chk(rv, 32'h2);
      chk({analog_supply_on, rf_enable}, 2'h2);
      apb(1'b1, PMS_ADDR_MODE, 32'h11);
      settle(2);
      chk(rf_enable, 1'b1);
      apb(1'b1, PMS_ADDR_MODE, 32'h10);
      apb(1'b0, 12'h020, 32'h0);
      chk(e, 1'b1);
      chk(rv, 32'h0);
      // Auxiliary regulator choice
      aux_above_battery <= 1'b1;
      settle(3);
      chk(aux_regulator_sel, 1'b1);
      apb(1'b0, PMS_ADDR_STAT, 32'h0);
      chk(rv[6], 1'b1);
      @(posedge pclk);
      aux_above_battery <= 1'b0;
      settle(3);
      chk(aux_regulator_sel, 1'b0);
      // Low battery between the two thresholds
      @(posedge pclk);
      output_supply_mv <= 16'h0924;
      settle(3);
      chk(mcu_reset_n, 1'b1);
      for (int k = 0; k < 4; k++) begin
         if (k == 2) output_supply_mv <= 16'h0bb8;
         apb(1'b0, PMS_ADDR_STAT, 32'h0);
         chk(rv[7], k < 3);
      end
      // Supply loss with the output supply enabled
      apb(1'b1, PMS_ADDR_MODE, 32'h2c);
      output_supply_mv <= 16'h07d0;
      settle(3);
      chk(mcu_reset_n, 1'b0);
      for (int k = 0; k < 6; k++) begin
         settle(1);
         chk(clk_out, 1'b0);
      end
      apb(1'b0, PMS_ADDR_STATE, 32'h0);
      chk(rv, 32'h0);
      output_supply_mv <= 16'h0bb8;
      wait_hi(4);
      apb(1'b0, PMS_ADDR_MODE, 32'h0);
      chk(rv[7:0], 8'h10);
      // Host switches the output supply off: no logic reset
      apb(1'b1, PMS_ADDR_MODE, 32'h2c);
      apb(1'b1, PMS_ADDR_CTRL, 32'h4);
      settle(3);
      chk({output_supply_on, mcu_reset_n}, 2'h0);
      @(posedge pclk);
      power_on_input <= 1'b1;
      wait_hi(4);
      apb(1'b0, PMS_ADDR_MODE, 32'h0);
      chk(rv[7:0], 8'h2c);
      power_on_input <= 1'b0;
      aux_above_threshold <= 1'b0;
      // Each switch-on pin (five buttons, power-on) from the powered-down state
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, PMS_ADDR_STAT, 32'h0);
         apb(1'b1, PMS_ADDR_CTRL, 32'h6);
         apb(1'b1, PMS_ADDR_CMD, {24'h0, PMS_CMD_OFF});
         settle(3);
         chk(logic_supply_on, 1'b0);
         @(posedge pclk);
         if (i < 5) button_input_n <= ~(5'h01 << i);
         else power_on_input <= 1'b1;
         wait_hi(3);
         wait_hi(4);
         apb(1'b0, PMS_ADDR_STAT, 32'h0);
         chk(rv[5:0], 6'h01 << i);
         apb(1'b0, PMS_ADDR_STATE, 32'h0);
         chk(rv, 32'h2);
         button_input_n <= 5'h1f;
         power_on_input <= 1'b0;
      end
      stop_test();
   end
endmodule : pms_sequencer_tb
`default_nettype wire
